// File: hw/fsf_pkg.sv
`default_nettype none
package fsf_pkg;
  // Parameter block in SRAM
  localparam logic [7:0] GUARD_VALUE = 8'h3A;
  localparam logic [7:0] PB_GUARD1 = 8'hF8;
  localparam logic [7:0] PB_GUARD2 = 8'hF9;
  localparam logic [7:0] PB_BLOCK = 8'hFA;
  localparam logic [7:0] PB_POINTER = 8'hFB;
  localparam logic [7:0] PB_DIVIDER = 8'hFC;
  localparam logic [7:0] PB_DELAY = 8'hFE;
  localparam logic [7:0] PROT_SRC_BASE = 8'h80;
  localparam logic [7:0] TABLE_DEST = 8'hF8;

  // Function codes held in the accumulator
  localparam logic [7:0] FN_BOOT = 8'h00;
  localparam logic [7:0] FN_WRITE = 8'h02;
  localparam logic [7:0] FN_ERASE = 8'h03;
  localparam logic [7:0] FN_PROTECT = 8'h04;
  localparam logic [7:0] FN_ERASE_ALL = 8'h05;
  localparam logic [7:0] FN_TABLE = 8'h06;
  localparam logic [7:0] FN_SUM = 8'h07;

  // Return codes left in the first guard byte
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_PROT = 8'h01;
  localparam logic [7:0] RC_SOFT = 8'h02;
  localparam logic [7:0] RC_FATAL = 8'h03;

  // Flash geometry
  localparam int FLASH_BYTES = 16384;
  localparam logic [7:0] PART_LAST_BLOCK = 8'h7F;
  localparam logic [5:0] BLOCK_LAST_BYTE = 6'h3F;
  localparam logic [13:0] ARRAY_LAST_BYTE = 14'h3FFF;
  localparam logic [2:0] TABLE_LAST_BYTE = 3'h7;
  localparam logic [2:0] ALT_TRIM_TABLE = 3'h1;
  localparam logic [1:0] LEVEL_INT_WRITE_OFF = 2'b11;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] PROGRAMMED_ZERO = 8'h00;
  localparam logic [2:0] PHASE_LAST = 3'h4;

  // Identity values; all arbitrary
  localparam logic [15:0] REVISION_ID = 16'h0101;
  localparam logic [7:0] INTERNAL_REV = 8'h00;
  localparam logic [511:0] TABLE_ROW = {496'h0, 16'h5A5A};

  // APB register map (byte addresses)
  localparam logic [1:0] REG_SRAM_PAGE = 2'h0;
  localparam logic [11:0] REG_CALL = 12'h400;
  localparam logic [11:0] REG_STATUS = 12'h404;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CHECK, ST_PULSE, ST_PROGRAM, ST_CLEAR, ST_PROTECT,
    ST_BULK, ST_TABLE, ST_SUM, ST_RET1, ST_RET2, ST_HALT
  } fsf_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fsf_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } fsf_apb_rsp_t;

  typedef struct packed {
    fsf_state_t st;
    fsf_state_t after;
    logic [7:0] func;
    logic [7:0] sp;
    logic [7:0] blk;
    logic [7:0] ptr;
    logic [13:0] cnt;
    logic [13:0] last;
    logic [2:0] phase;
    logic [15:0] pulseLen;
    logic [15:0] pulse;
    logic [15:0] sum;
    logic [7:0] ret1;
    logic [7:0] ret2;
    logic [7:0] acc;
    logic [7:0] idx;
    logic [31:0] rdata;
  } fsf_regs_t;
endpackage
`default_nettype wire

// File: hw/fsf_flash_supervisor.sv
// How it works
// - Program block index must fit the part size, else halt.
// - Block program copies 64 SRAM bytes from buffer pointer into flash.
// - Divider times delay parameter sets program and erase pulse length.
// - Block clear empties 64 bytes only if block is writable.
// - Protected clear aborts with accumulator, guard two 00h, guard one 01h.
// - Clearing a block leaves its protection level alone.
// - Each block has a two-bit protection level.
// - Four levels per byte, lowest block in lowest bits.
// - Protection set ORs SRAM from 80h upward into protection bytes.
// - Only whole-array clear lowers protection, writing zeros.
// - Whole clear: erase, zeros, erase; then protection erase and zeros.
// - Hidden blocks above the protection block stay untouched.
// - Factory table row is 64 bytes, eight tables of eight.
// - Table fetch uses index bits 2:0, copies into SRAM F8h-FFh.
// - Table fetch returns the 16-bit revision in accumulator and index.
// - Alternate trim table gives index FFh, internal revision in accumulator.
// - Checksum counts blocks from zero; count 0 means 256 blocks.
// - Each byte adds into guard one with carry into guard two.
// - Checksum low byte lands in guard one, high in guard two.
// - Guard mismatch halts the core, except for boot reset.
// - Return codes: 00h ok, 01h protected, 02h reset, 03h halt.
`default_nettype none
module fsf_flash_supervisor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB register bus
  input wire fsf_pkg::fsf_apb_req_t apbReq,
  output var fsf_pkg::fsf_apb_rsp_t apbRsp,
  // Service state
  output var logic serviceBusy,
  output var logic cpuHalted
);

  fsf_pkg::fsf_regs_t s;
  fsf_pkg::fsf_regs_t next_s;

  // Core SRAM, flash array and protection block
  logic [7:0] sram [256];
  logic [7:0] flash [fsf_pkg::FLASH_BYTES];
  logic [7:0] prot [64];

  logic sWe;
  logic [7:0] sAddr;
  logic [7:0] sData;
  logic fWe;
  logic [13:0] fAddr;
  logic [7:0] fData;
  logic pWe;
  logic [5:0] pIdx;
  logic [7:0] pData;

  logic setupPh;
  logic accessPh;
  logic isSram;
  logic isCall;
  logic isStatus;
  logic busy;
  logic halted;
  logic refuse;
  logic [7:0] apbIdx;
  logic [7:0] pbBlock;
  logic [1:0] level;
  logic guardOk;
  logic knownFn;
  logic [31:0] readMux;

  // Bus decode
  assign setupPh = apbReq.psel & ~apbReq.penable;
  assign accessPh = apbReq.psel & apbReq.penable;
  assign isSram = apbReq.paddr[11:10] == fsf_pkg::REG_SRAM_PAGE;
  assign isCall = apbReq.paddr == fsf_pkg::REG_CALL;
  assign isStatus = apbReq.paddr == fsf_pkg::REG_STATUS;
  assign apbIdx = apbReq.paddr[9:2];
  assign busy = s.st != fsf_pkg::ST_IDLE && s.st != fsf_pkg::ST_HALT;
  assign halted = s.st == fsf_pkg::ST_HALT;
  assign refuse = apbReq.pwrite
    & ((isSram & busy) | (isCall & (busy | halted)));

  // Protection level of the block named in the parameter block
  assign pbBlock = sram[fsf_pkg::PB_BLOCK];
  assign level = prot[pbBlock[7:2]][{pbBlock[1:0], 1'b0} +: 2];
  assign guardOk = sram[fsf_pkg::PB_GUARD1] == fsf_pkg::GUARD_VALUE
    && sram[fsf_pkg::PB_GUARD2] == s.sp;
  assign knownFn = s.func == fsf_pkg::FN_WRITE
    || s.func == fsf_pkg::FN_ERASE || s.func == fsf_pkg::FN_PROTECT
    || s.func == fsf_pkg::FN_ERASE_ALL || s.func == fsf_pkg::FN_TABLE
    || s.func == fsf_pkg::FN_SUM;

  // Read data selection
  always_comb begin
    readMux = 32'h0;
    if (isSram) begin
      readMux = {24'h0, sram[apbIdx]};
    end else if (isCall) begin
      readMux = {16'h0, s.sp, s.func};
    end else if (isStatus) begin
      readMux = {8'h0, s.idx, s.acc, 6'h0, halted, busy};
    end
  end

  // Bus answer: zero wait states, error on unmapped or refused access
  always_comb begin
    apbRsp.pready = 1'b1;
    apbRsp.prdata = s.rdata;
    apbRsp.pslverr = accessPh & (~(isSram | isCall | isStatus) | refuse);
  end

  assign serviceBusy = busy;
  assign cpuHalted = halted;

  // Service sequencer and bus writes
  always_comb begin
    next_s = s;
    sWe = 1'b0;
    sAddr = apbIdx;
    sData = apbReq.pwdata[7:0];
    fWe = 1'b0;
    fAddr = {s.blk, s.cnt[5:0]};
    fData = fsf_pkg::ERASED_BYTE;
    pWe = 1'b0;
    pIdx = s.cnt[5:0];
    pData = fsf_pkg::PROGRAMMED_ZERO;
    if (setupPh) begin
      next_s.rdata = readMux;
    end
    if (accessPh & apbReq.pwrite & ~refuse) begin
      if (isSram) begin
        sWe = 1'b1;
      end else if (isCall) begin
        next_s.func = apbReq.pwdata[7:0];
        next_s.sp = apbReq.pwdata[15:8];
        next_s.st = fsf_pkg::ST_CHECK;
      end
    end
    case (s.st)
      fsf_pkg::ST_IDLE: begin
      end
      fsf_pkg::ST_CHECK: begin
        next_s.blk = pbBlock;
        next_s.ptr = sram[fsf_pkg::PB_POINTER];
        next_s.cnt = 14'h0;
        next_s.ret2 = 8'h00;
        next_s.acc = 8'h00;
        next_s.after = fsf_pkg::ST_RET1;
        next_s.pulseLen = {8'h0, sram[fsf_pkg::PB_DIVIDER]}
          * {8'h0, sram[fsf_pkg::PB_DELAY]};
        next_s.pulse = next_s.pulseLen;
        if (s.func == fsf_pkg::FN_BOOT) begin
          sWe = 1'b1;
          sAddr = fsf_pkg::PB_GUARD1;
          sData = fsf_pkg::RC_SOFT;
          next_s.st = fsf_pkg::ST_IDLE;
        end else if (!guardOk || !knownFn || ((s.func == fsf_pkg::FN_WRITE
            || s.func == fsf_pkg::FN_ERASE)
            && pbBlock > fsf_pkg::PART_LAST_BLOCK)) begin
          sWe = 1'b1;
          sAddr = fsf_pkg::PB_GUARD1;
          sData = fsf_pkg::RC_FATAL;
          next_s.st = fsf_pkg::ST_HALT;
        end else begin
          case (s.func)
            fsf_pkg::FN_WRITE, fsf_pkg::FN_ERASE: begin
              if (level == fsf_pkg::LEVEL_INT_WRITE_OFF) begin
                next_s.ret1 = fsf_pkg::RC_PROT;
                next_s.st = fsf_pkg::ST_RET1;
              end else begin
                next_s.st = fsf_pkg::ST_PULSE;
                next_s.after = (s.func == fsf_pkg::FN_WRITE)
                  ? fsf_pkg::ST_PROGRAM : fsf_pkg::ST_CLEAR;
              end
            end
            fsf_pkg::FN_PROTECT: begin
              next_s.st = fsf_pkg::ST_PULSE;
              next_s.after = fsf_pkg::ST_PROTECT;
            end
            fsf_pkg::FN_ERASE_ALL: begin
              next_s.phase = 3'h0;
              next_s.st = fsf_pkg::ST_PULSE;
              next_s.after = fsf_pkg::ST_BULK;
            end
            fsf_pkg::FN_TABLE: begin
              next_s.st = fsf_pkg::ST_TABLE;
            end
            default: begin
              next_s.sum = 16'h0;
              next_s.last = {8'(pbBlock - 8'h01),
                fsf_pkg::BLOCK_LAST_BYTE};
              next_s.st = fsf_pkg::ST_SUM;
            end
          endcase
        end
      end
      fsf_pkg::ST_PULSE: begin
        // Program or erase pulse; calls are refused while it runs
        if (s.pulse == 16'h0) begin
          next_s.st = s.after;
        end else begin
          next_s.pulse = s.pulse - 16'h1;
        end
      end
      fsf_pkg::ST_PROGRAM: begin
        fWe = 1'b1;
        fData = sram[8'(s.ptr + {2'b0, s.cnt[5:0]})];
        next_s.cnt = s.cnt + 14'h1;
        if (s.cnt[5:0] == fsf_pkg::BLOCK_LAST_BYTE) begin
          next_s.ret1 = fsf_pkg::RC_OK;
          next_s.st = fsf_pkg::ST_RET1;
        end
      end
      fsf_pkg::ST_CLEAR: begin
        // Protection block is not written here
        fWe = 1'b1;
        next_s.cnt = s.cnt + 14'h1;
        if (s.cnt[5:0] == fsf_pkg::BLOCK_LAST_BYTE) begin
          next_s.ret1 = fsf_pkg::RC_OK;
          next_s.st = fsf_pkg::ST_RET1;
        end
      end
      fsf_pkg::ST_PROTECT: begin
        pWe = 1'b1;
        pData = prot[s.cnt[5:0]]
          | sram[8'(fsf_pkg::PROT_SRC_BASE + {2'b0, s.cnt[5:0]})];
        next_s.cnt = s.cnt + 14'h1;
        if (s.cnt[5:0] == fsf_pkg::BLOCK_LAST_BYTE) begin
          next_s.ret1 = fsf_pkg::RC_OK;
          next_s.st = fsf_pkg::ST_RET1;
        end
      end
      fsf_pkg::ST_BULK: begin
        // Single macro: user erase, zeros, erase, then protection
        // erase and zeros; hidden blocks have no write path
        fAddr = s.cnt;
        next_s.cnt = s.cnt + 14'h1;
        if (s.phase < 3'h3) begin
          fWe = 1'b1;
          fData = (s.phase == 3'h1) ? fsf_pkg::PROGRAMMED_ZERO
            : fsf_pkg::ERASED_BYTE;
        end else begin
          pWe = 1'b1;
          pData = (s.phase == fsf_pkg::PHASE_LAST)
            ? fsf_pkg::PROGRAMMED_ZERO : fsf_pkg::ERASED_BYTE;
        end
        if ((s.phase < 3'h3 && s.cnt == fsf_pkg::ARRAY_LAST_BYTE)
            || (s.phase >= 3'h3
            && s.cnt[5:0] == fsf_pkg::BLOCK_LAST_BYTE)) begin
          next_s.cnt = 14'h0;
          next_s.phase = s.phase + 3'h1;
          next_s.pulse = s.pulseLen;
          next_s.st = fsf_pkg::ST_PULSE;
          if (s.phase == fsf_pkg::PHASE_LAST) begin
            next_s.ret1 = fsf_pkg::RC_OK;
            next_s.st = fsf_pkg::ST_RET1;
          end
        end
      end
      fsf_pkg::ST_TABLE: begin
        sWe = 1'b1;
        sAddr = fsf_pkg::TABLE_DEST + {5'h0, s.cnt[2:0]};
        sData = fsf_pkg::TABLE_ROW[{s.blk[2:0], s.cnt[2:0], 3'h0}
          +: 8];
        next_s.cnt = s.cnt + 14'h1;
        if (s.cnt[2:0] == fsf_pkg::TABLE_LAST_BYTE) begin
          next_s.st = fsf_pkg::ST_IDLE;
          if (s.blk[2:0] == fsf_pkg::ALT_TRIM_TABLE) begin
            next_s.idx = 8'hFF;
            next_s.acc = fsf_pkg::INTERNAL_REV;
          end else begin
            next_s.acc = fsf_pkg::REVISION_ID[15:8];
            next_s.idx = fsf_pkg::REVISION_ID[7:0];
          end
        end
      end
      fsf_pkg::ST_SUM: begin
        next_s.sum = s.sum + {8'h0, flash[s.cnt]};
        next_s.cnt = s.cnt + 14'h1;
        if (s.cnt == s.last) begin
          next_s.ret1 = next_s.sum[7:0];
          next_s.ret2 = next_s.sum[15:8];
          next_s.st = fsf_pkg::ST_RET1;
        end
      end
      fsf_pkg::ST_RET1: begin
        sWe = 1'b1;
        sAddr = fsf_pkg::PB_GUARD1;
        sData = s.ret1;
        next_s.st = fsf_pkg::ST_RET2;
      end
      fsf_pkg::ST_RET2: begin
        sWe = 1'b1;
        sAddr = fsf_pkg::PB_GUARD2;
        sData = s.ret2;
        next_s.st = fsf_pkg::ST_IDLE;
      end
      fsf_pkg::ST_HALT: begin
        next_s.st = fsf_pkg::ST_HALT;
      end
      default: begin
        next_s.st = fsf_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Memory write ports
  always_ff @(posedge clk) begin
    if (sWe) begin
      sram[sAddr] <= sData;
    end
    if (fWe) begin
      flash[fAddr] <= fData;
    end
    if (pWe) begin
      prot[pIdx] <= pData;
    end
  end

endmodule
`default_nettype wire

// File: verif/fsf_flash_supervisor_chk.sv
`default_nettype none
module fsf_flash_supervisor_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire fsf_pkg::fsf_apb_req_t apbReq,
  input wire fsf_pkg::fsf_apb_rsp_t apbRsp,
  input wire logic serviceBusy,
  input wire logic cpuHalted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic inAcc;
  logic callWr;
  logic sramWr;
  // Access phase decodes
  assign inAcc = apbReq.psel && apbReq.penable;
  assign callWr = inAcc && apbReq.pwrite &&
    apbReq.paddr == fsf_pkg::REG_CALL;
  assign sramWr = inAcc && apbReq.pwrite && apbReq.paddr < 12'h400;
  // Accepted call, and the setup of a status read
  sequence callTaken;
    callWr && !apbRsp.pslverr;
  endsequence
  sequence statSetup;
    apbReq.psel && !apbReq.penable && !apbReq.pwrite &&
      apbReq.paddr == fsf_pkg::REG_STATUS;
  endsequence
  a_call_busy: assert property (callTaken |=> serviceBusy)
    else $error("call did not start a service");
  a_busy_refuse: assert property (
    callWr && serviceBusy |-> apbRsp.pslverr)
    else $error("call accepted while busy");
  a_halt_refuse: assert property (
    callWr && cpuHalted |-> apbRsp.pslverr)
    else $error("call accepted while halted");
  a_halt_sticky: assert property (cpuHalted |=> cpuHalted)
    else $error("halt left without reset");
  a_halt_entry: assert property (
    $rose(cpuHalted) |-> $past(serviceBusy))
    else $error("halt outside a service");
  a_status_bits: assert property (statSetup |=>
    apbRsp.prdata[0] == $past(serviceBusy) &&
    apbRsp.prdata[1] == $past(cpuHalted))
    else $error("status bits wrong");
  a_zero_wait: assert property (inAcc |-> apbRsp.pready)
    else $error("wait state inserted");
  a_sram_locked: assert property (
    sramWr && serviceBusy |-> apbRsp.pslverr)
    else $error("buffer write accepted while busy");
endmodule
bind fsf_flash_supervisor fsf_flash_supervisor_chk u_chk (.clk(clk),
  .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
  .serviceBusy(serviceBusy), .cpuHalted(cpuHalted));
`default_nettype wire

// File: verif/fsf_cpu_model.sv
`default_nettype none
module fsf_cpu_model (
  // Clock
  input wire logic clk,
  // Bus master side
  output var fsf_pkg::fsf_apb_req_t apbReq,
  input wire fsf_pkg::fsf_apb_rsp_t apbRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SP = 8'h40;
  logic hang = 1'b0;
  logic [31:0] q;
  logic e;
  initial apbReq = '0;
  // One transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 64);
    hang |= apbRsp.pready !== 1'b1;
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk);
  endtask
  // Write one buffer byte
  task automatic sw(input logic [7:0] i, v);
    xfer(1'b1, {2'h0, i, 2'h0}, {24'h0, v}, q, e);
  endtask
  // Fill the parameter block and issue the call; short delay, fast clock
  task automatic call(input logic [7:0] fn, blk, ptr, key);
    sw(fsf_pkg::PB_GUARD1, key);
    sw(fsf_pkg::PB_GUARD2, SP);
    sw(fsf_pkg::PB_BLOCK, blk);
    sw(fsf_pkg::PB_POINTER, ptr);
    sw(fsf_pkg::PB_DIVIDER, 8'h01);
    sw(fsf_pkg::PB_DELAY, 8'h02);
    xfer(1'b1, fsf_pkg::REG_CALL, {16'h0, SP, fn}, q, e);
  endtask
  // Poll status until the service has ended
  task automatic poll();
    int n;
    n = 0;
    do begin
      xfer(1'b0, fsf_pkg::REG_STATUS, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 20000);
    hang |= q[0] !== 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/flash_supervisor_functions_tb_top.sv
`default_nettype none
module flash_supervisor_functions_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fsf_pkg::fsf_apb_req_t apbReq;
  fsf_pkg::fsf_apb_rsp_t apbRsp;
  logic serviceBusy;
  logic cpuHalted;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] q;
  logic e;
  // Design and the core model driving it
  fsf_flash_supervisor uut (.clk(clk), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .serviceBusy(serviceBusy), .cpuHalted(cpuHalted));
  fsf_cpu_model cpu (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));
  // Clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] x, g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    if (cpu.hang) n_mismatch++;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Read one buffer byte and compare it
  task automatic sb(input logic [7:0] i, x);
    cpu.xfer(1'b0, {2'h0, i, 2'h0}, 32'h0, q, e);
    chk("sram byte", {24'h0, x}, {24'h0, q[7:0]});
  endtask
  // Read status and compare the masked fields
  task automatic st(input logic [31:0] m, x);
    cpu.xfer(1'b0, fsf_pkg::REG_STATUS, 32'h0, q, e);
    chk("status", x, q & m);
  endtask
  // Run one service; check the first guard byte afterwards
  task automatic svc(input logic [7:0] fn, blk, rc);
    cpu.call(fn, blk, 8'h10, fsf_pkg::GUARD_VALUE);
    cpu.poll();
    if (cpu.hang) test_done();
    sb(fsf_pkg::PB_GUARD1, rc);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cpu.call(fsf_pkg::FN_ERASE_ALL, 8'h00, 8'h00, fsf_pkg::GUARD_VALUE);
    cpu.xfer(1'b1, fsf_pkg::REG_CALL, 32'h4007, q, e);
    chk("busy call", 1, e);
    cpu.xfer(1'b1, 12'h010, 32'h55, q, e);
    chk("busy sram", 1, e);
    // Call word keeps the accepted call, not the refused one
    cpu.xfer(1'b0, fsf_pkg::REG_CALL, 32'h0, q, e);
    chk("call word", {16'h0, cpu.SP, fsf_pkg::FN_ERASE_ALL}, q);
    cpu.poll();
    sb(fsf_pkg::PB_GUARD1, fsf_pkg::RC_OK);
    svc(fsf_pkg::FN_SUM, 8'h01, 8'hC0);
    sb(fsf_pkg::PB_GUARD2, 8'h3F);
    // Count zero covers all 256 erased blocks
    svc(fsf_pkg::FN_SUM, 8'h00, 8'h00);
    sb(fsf_pkg::PB_GUARD2, 8'hC0);
    // Source data and a clean protection image
    for (int i = 0; i < 64; i++) begin
      cpu.sw(8'(16 + i), 8'(16 + i));
      cpu.sw(8'(128 + i), 8'h00);
    end
    svc(fsf_pkg::FN_WRITE, 8'h02, fsf_pkg::RC_OK);
    svc(fsf_pkg::FN_SUM, 8'h03, 8'h60);
    sb(fsf_pkg::PB_GUARD2, 8'h8B);
    svc(fsf_pkg::FN_ERASE, 8'h02, fsf_pkg::RC_OK);
    svc(fsf_pkg::FN_SUM, 8'h03, 8'h40);
    sb(fsf_pkg::PB_GUARD2, 8'hBF);
    // Block 3 fully protected, block 2 external writes off
    cpu.sw(fsf_pkg::PROT_SRC_BASE, 8'hE0);
    svc(fsf_pkg::FN_PROTECT, 8'h00, fsf_pkg::RC_OK);
    svc(fsf_pkg::FN_ERASE, 8'h03, fsf_pkg::RC_PROT);
    sb(fsf_pkg::PB_GUARD2, 8'h00);
    st(32'h0000FF00, 32'h0);
    svc(fsf_pkg::FN_WRITE, 8'h03, fsf_pkg::RC_PROT);
    svc(fsf_pkg::FN_ERASE, 8'h02, fsf_pkg::RC_OK);
    cpu.sw(fsf_pkg::PROT_SRC_BASE, 8'h00);
    svc(fsf_pkg::FN_PROTECT, 8'h00, fsf_pkg::RC_OK);
    svc(fsf_pkg::FN_ERASE, 8'h03, fsf_pkg::RC_PROT);
    // Cleared block 2 then programmed with zeros from the 80h area
    cpu.call(fsf_pkg::FN_WRITE, 8'h02, fsf_pkg::PROT_SRC_BASE,
      fsf_pkg::GUARD_VALUE);
    cpu.poll();
    sb(fsf_pkg::PB_GUARD1, fsf_pkg::RC_OK);
    svc(fsf_pkg::FN_SUM, 8'h03, 8'h80);
    sb(fsf_pkg::PB_GUARD2, 8'h7F);
    // Factory tables; upper index bits ignored
    svc(fsf_pkg::FN_TABLE, 8'hF8, fsf_pkg::TABLE_ROW[7:0]);
    for (int i = 1; i < 8; i++) begin
      sb(8'(248 + i), fsf_pkg::TABLE_ROW[8 * i +: 8]);
    end
    st(32'h00FFFF00, {8'h0, fsf_pkg::REVISION_ID[7:0],
      fsf_pkg::REVISION_ID[15:8], 8'h0});
    svc(fsf_pkg::FN_TABLE, 8'hF9, fsf_pkg::TABLE_ROW[71:64]);
    st(32'h00FFFF00, {16'h00FF, fsf_pkg::INTERNAL_REV, 8'h0});
    // Unmapped place
    cpu.xfer(1'b0, 12'h408, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    // Boot reset ignores the guard bytes
    cpu.call(fsf_pkg::FN_BOOT, 8'h00, 8'h00, 8'h00);
    cpu.poll();
    sb(fsf_pkg::PB_GUARD1, fsf_pkg::RC_SOFT);
    // Block out of range halts; calls refused until reset
    svc(fsf_pkg::FN_WRITE, 8'h80, fsf_pkg::RC_FATAL);
    cpu.xfer(1'b1, fsf_pkg::REG_CALL, 32'h4007, q, e);
    chk("halt call", 1, e);
    st(32'h3, 32'h2);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    st(32'h3, 32'h0);
    cpu.call(fsf_pkg::FN_SUM, 8'h01, 8'h00, 8'h3B);
    cpu.poll();
    sb(fsf_pkg::PB_GUARD1, fsf_pkg::RC_FATAL);
    st(32'h3, 32'h2);
    test_done();
  end
endmodule
`default_nettype wire
